// ===== rtl/flash_guard_pkg.sv
// Package with the register map, field positions and carriers of the flash sector access guard.
package flash_guard_pkg;

  // ==========================================================================
  // Register bus and offsets
  // ==========================================================================
  localparam int ADDR_W = 8;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LOCKOUT_OFS = 8'h04;
  localparam logic [7:0] GUARD_OFS = 8'h08;
  localparam logic [7:0] PRIV_OFS = 8'h0C;
  localparam logic [7:0] FETCH_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;

  // ==========================================================================
  // Field positions and codes
  // ==========================================================================
  localparam int LOCK_BIT = 10;
  localparam int KEYSEL_BIT = 5;
  localparam int BACKDOOR_UNLOCK_ENABLE_BIT = 31;
  localparam int LOCKOUT_STATE_BIT_BIT = 30;
  localparam int CODE_W = 16;
  localparam logic [15:0] SECURE_CODE = 16'h4AC8;
  localparam int CMD_BUFFER_EMPTY_FLAG_BIT = 7;
  localparam int CMD_COMPLETE_FLAG_BIT = 6;
  localparam int PROTECTION_VIOLATION_FLAG_BIT = 5;
  localparam int ACCESS_ERROR_FLAG_BIT = 4;
  localparam int BLANK_BIT = 2;
  localparam int STATUS_W = 8;
  localparam logic [7:0] STATUS_RESET = 8'hC0;

  // ==========================================================================
  // Sector geometry and configuration field
  // ==========================================================================
  localparam int SECTORS = 32;
  localparam int SECTOR_LSB = 13;
  localparam int FLASH_AW = 18;
  localparam int CFG_AW = 16;
  localparam logic [15:0] CFG_GUARD_OFS = 16'h0410;
  localparam logic [15:0] CFG_PRIV_OFS = 16'h0408;
  localparam logic [15:0] CFG_FETCH_OFS = 16'h040C;
  localparam logic [15:0] CFG_LOCKOUT_OFS = 16'h0414;

  typedef enum logic [1:0] {
    LD_GUARD = 2'h0,
    LD_PRIV = 2'h1,
    LD_FETCH = 2'h2,
    LD_LOCKOUT = 2'h3
  } load_sel_e;

  typedef struct packed {
    logic valid;
    logic write;
    logic user;
    logic fetch;
    logic [FLASH_AW-1:0] addr;
  } acc_req_s;

  typedef struct packed {
    logic cmd_buffer_empty_flag;
    logic access_error_flag;
    logic blank;
  } flag_set_s;

endpackage : flash_guard_pkg

// ===== rtl/config_loader.sv
// Reset-time loader that fetches the protection words from the flash configuration field.
`timescale 1ns/1ns
module config_loader (
  input wire logic sys_clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  output logic cfg_req, // Read request to the flash array.
  output logic [flash_guard_pkg::CFG_AW-1:0] cfg_addr, // Byte offset of the requested word.
  input wire logic cfg_valid, // Requested word present on cfg_data.
  input wire logic [31:0] cfg_data, // Word read from the flash array.
  output logic ld_strobe, // One-cycle load of ld_data into a register.
  output flash_guard_pkg::load_sel_e ld_sel, // Register that ld_data is meant for.
  output logic [31:0] ld_data, // Loaded word.
  output logic load_done // Reset sequence finished.
);

  typedef enum logic [2:0] {
    ST_GUARD = 3'b000,
    ST_PRIV = 3'b001,
    ST_FETCH = 3'b011,
    ST_LOCKOUT = 3'b010,
    ST_DONE = 3'b110
  } load_state_e;

  load_state_e state_reg, state_next;
  logic req_reg, req_next;
  logic [flash_guard_pkg::CFG_AW-1:0] addr_reg, addr_next;
  logic strobe_reg, strobe_next;
  flash_guard_pkg::load_sel_e sel_reg, sel_next;
  logic [31:0] data_reg, data_next;

  // ==========================================================================
  // Sequence of configuration reads
  // ==========================================================================
  always_comb begin
    state_next = state_reg;
    req_next = 1'b0;
    addr_next = addr_reg;
    strobe_next = 1'b0;
    sel_next = sel_reg;
    data_next = data_reg;
    unique case (state_reg)
      ST_GUARD: begin
        req_next = 1'b1;
        addr_next = flash_guard_pkg::CFG_GUARD_OFS;
        sel_next = flash_guard_pkg::LD_GUARD;
      end
      ST_PRIV: begin
        req_next = 1'b1;
        addr_next = flash_guard_pkg::CFG_PRIV_OFS;
        sel_next = flash_guard_pkg::LD_PRIV;
      end
      ST_FETCH: begin
        req_next = 1'b1;
        addr_next = flash_guard_pkg::CFG_FETCH_OFS;
        sel_next = flash_guard_pkg::LD_FETCH;
      end
      ST_LOCKOUT: begin
        req_next = 1'b1;
        addr_next = flash_guard_pkg::CFG_LOCKOUT_OFS;
        sel_next = flash_guard_pkg::LD_LOCKOUT;
      end
      default: begin
        state_next = ST_DONE;
      end
    endcase
    // The request and the address are registered together, so a reply counts from the first cycle the request stands.
    if (req_reg && cfg_valid) begin
      req_next = 1'b0;
      strobe_next = 1'b1;
      data_next = cfg_data;
      unique case (state_reg)
        ST_GUARD: state_next = ST_PRIV;
        ST_PRIV: state_next = ST_FETCH;
        ST_FETCH: state_next = ST_LOCKOUT;
        default: state_next = ST_DONE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_GUARD;
      req_reg <= 1'b0;
      addr_reg <= '0;
      strobe_reg <= 1'b0;
      sel_reg <= flash_guard_pkg::LD_GUARD;
      data_reg <= '0;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      addr_reg <= addr_next;
      strobe_reg <= strobe_next;
      sel_reg <= sel_next;
      data_reg <= data_next;
    end
  end

  assign cfg_req = req_reg;
  assign cfg_addr = addr_reg;
  assign ld_strobe = strobe_reg;
  assign ld_sel = sel_reg;
  assign ld_data = data_reg;
  assign load_done = (state_reg == ST_DONE) && !strobe_reg;

  a_lockout_fetch: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (req_reg && state_reg == ST_LOCKOUT) |-> addr_reg == flash_guard_pkg::CFG_LOCKOUT_OFS)
    else $error("lockout word not fetched from its configuration offset");

endmodule : config_loader

// ===== rtl/sector_access_check.sv
// Per-access check of flash accesses against the sector guard, privilege and fetch masks.
`timescale 1ns/1ns
module sector_access_check (
  input wire logic sys_clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input flash_guard_pkg::acc_req_s acc_req, // Access presented by the core.
  input wire logic [flash_guard_pkg::SECTORS-1:0] guard_mask, // Program/erase guard per sector.
  input wire logic [flash_guard_pkg::SECTORS-1:0] priv_mask, // Supervisor-only per sector.
  input wire logic [flash_guard_pkg::SECTORS-1:0] fetch_mask, // Data-only per sector.
  input wire logic launch_block, // Command launch refused.
  output logic acc_done, // One-cycle end of the access.
  output logic acc_bus_err, // Access ended with a transfer error.
  output logic acc_grant, // Program/erase accepted for the controller.
  output logic prot_event // Program/erase hit a guarded sector.
);

  logic [4:0] sector;
  logic done_reg, done_next;
  logic err_reg, err_next;
  logic grant_reg, grant_next;
  logic pv_reg, pv_next;

  // ==========================================================================
  // Decision
  // ==========================================================================
  assign sector = acc_req.addr[flash_guard_pkg::FLASH_AW-1:flash_guard_pkg::SECTOR_LSB];

  always_comb begin
    done_next = acc_req.valid;
    err_next = 1'b0;
    grant_next = 1'b0;
    pv_next = 1'b0;
    if (acc_req.valid) begin
      if ((acc_req.user && priv_mask[sector]) || (acc_req.fetch && fetch_mask[sector])) begin
        err_next = 1'b1;
      end else if (acc_req.write) begin
        if (guard_mask[sector]) begin
          pv_next = 1'b1;
        end else begin
          grant_next = !launch_block;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      grant_reg <= 1'b0;
      pv_reg <= 1'b0;
    end else begin
      done_reg <= done_next;
      err_reg <= err_next;
      grant_reg <= grant_next;
      pv_reg <= pv_next;
    end
  end

  assign acc_done = done_reg;
  assign acc_bus_err = err_reg;
  assign acc_grant = grant_reg;
  assign prot_event = pv_reg;

  a_guard_blocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (acc_req.valid && acc_req.write && guard_mask[sector]) |=> !acc_grant)
    else $error("program or erase granted on a guarded sector");
  a_fetch_error: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (acc_req.valid && acc_req.fetch && fetch_mask[sector]) |=> acc_done && acc_bus_err)
    else $error("instruction fetch from data-only sector not refused");
  a_priv_error: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (acc_req.valid && acc_req.user && priv_mask[sector]) |=> acc_bus_err && !acc_grant)
    else $error("user access to supervisor sector not refused");

endmodule : sector_access_check

// ===== rtl/flash_sector_access_guard.sv
// Top of the flash sector access guard: register file, status flags, reset load and access check.
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ns
module flash_sector_access_guard (
  input wire logic sys_clk, // System clock, 250 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [flash_guard_pkg::ADDR_W-1:0] reg_addr, // Register byte address.
  input wire logic [31:0] reg_wdata, // Register write data.
  input wire logic reg_wr, // Write strobe.
  input wire logic reg_rd, // Read strobe.
  output logic [31:0] reg_rdata, // Read data, the cycle after reg_rd.
  output logic cfg_req, // Configuration read request.
  output logic [flash_guard_pkg::CFG_AW-1:0] cfg_addr, // Configuration word offset.
  input wire logic cfg_valid, // Configuration word valid.
  input wire logic [31:0] cfg_data, // Configuration word.
  output logic load_done, // Reset load finished.
  input flash_guard_pkg::acc_req_s acc_req, // Flash access from the core.
  output logic acc_done, // Access finished.
  output logic acc_bus_err, // Access transfer error.
  output logic acc_grant, // Program/erase passed to the command controller.
  input flash_guard_pkg::flag_set_s flag_set, // Flag set pulses from the command controller.
  input wire logic cmd_complete, // Command-complete level from the command controller.
  output logic [flash_guard_pkg::STATUS_W-1:0] status_out_bus, // Status flags at the boundary.
  output logic cmd_launch_block, // Launch refused while an error flag stands.
  output logic key_write_select, // Flash writes are security keys.
  output logic backdoor_unlock_enable, // Backdoor key access allowed.
  output logic lockout_state_bit // Flash security active.
);

  // ==========================================================================
  // State
  // ==========================================================================
  logic lock_reg, lock_next;
  logic keysel_reg, keysel_next;
  logic backdoor_unlock_enable_reg, backdoor_unlock_enable_next;
  logic secure_reg, secure_next;
  logic [flash_guard_pkg::CODE_W-1:0] code_reg, code_next;
  logic [flash_guard_pkg::SECTORS-1:0] guard_reg, guard_next;
  logic [flash_guard_pkg::SECTORS-1:0] priv_reg, priv_next;
  logic [flash_guard_pkg::SECTORS-1:0] fetch_reg, fetch_next;
  logic [flash_guard_pkg::STATUS_W-1:0] status_reg, status_next;
  logic block_reg, block_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ld_strobe;
  flash_guard_pkg::load_sel_e ld_sel;
  logic [31:0] ld_data;
  logic prot_event;
  logic wr_ctrl, wr_guard, wr_priv, wr_fetch, wr_status;

  assign wr_ctrl = reg_wr && reg_addr == flash_guard_pkg::CTRL_OFS;
  assign wr_guard = reg_wr && reg_addr == flash_guard_pkg::GUARD_OFS;
  assign wr_priv = reg_wr && reg_addr == flash_guard_pkg::PRIV_OFS;
  assign wr_fetch = reg_wr && reg_addr == flash_guard_pkg::FETCH_OFS;
  assign wr_status = reg_wr && reg_addr == flash_guard_pkg::STATUS_OFS;

  // ==========================================================================
  // Reset-time load and access check
  // ==========================================================================
  config_loader u_loader (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .cfg_req(cfg_req),
    .cfg_addr(cfg_addr),
    .cfg_valid(cfg_valid),
    .cfg_data(cfg_data),
    .ld_strobe(ld_strobe),
    .ld_sel(ld_sel),
    .ld_data(ld_data),
    .load_done(load_done)
  );

  sector_access_check u_check (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .acc_req(acc_req),
    .guard_mask(guard_reg),
    .priv_mask(priv_reg),
    .fetch_mask(fetch_reg),
    .launch_block(block_reg),
    .acc_done(acc_done),
    .acc_bus_err(acc_bus_err),
    .acc_grant(acc_grant),
    .prot_event(prot_event)
  );

  // ==========================================================================
  // Control, lockout and mask registers
  // ==========================================================================
  always_comb begin
    lock_next = lock_reg;
    keysel_next = keysel_reg;
    backdoor_unlock_enable_next = backdoor_unlock_enable_reg;
    code_next = code_reg;
    guard_next = guard_reg;
    priv_next = priv_reg;
    fetch_next = fetch_reg;
    // Once set, the lock holds until reset; a later write of zero is ignored.
    if (wr_ctrl && !lock_reg) begin
      lock_next = reg_wdata[flash_guard_pkg::LOCK_BIT];
    end
    if (wr_ctrl && backdoor_unlock_enable_reg) begin
      keysel_next = reg_wdata[flash_guard_pkg::KEYSEL_BIT];
    end
    if (!backdoor_unlock_enable_reg) begin
      keysel_next = 1'b0;
    end
    if (wr_guard && !lock_reg) begin
      guard_next = reg_wdata;
    end
    if (wr_priv && !lock_reg) begin
      priv_next = reg_wdata;
    end
    if (wr_fetch && !lock_reg) begin
      fetch_next = reg_wdata;
    end
    // The lockout word has no write path at all: only the reset load changes it.
    if (ld_strobe) begin
      unique case (ld_sel)
        flash_guard_pkg::LD_GUARD: guard_next = ld_data;
        flash_guard_pkg::LD_PRIV: priv_next = ld_data;
        flash_guard_pkg::LD_FETCH: fetch_next = ld_data;
        flash_guard_pkg::LD_LOCKOUT: begin
          backdoor_unlock_enable_next = ld_data[flash_guard_pkg::BACKDOOR_UNLOCK_ENABLE_BIT];
          code_next = ld_data[flash_guard_pkg::CODE_W-1:0];
        end
      endcase
    end
    secure_next = (code_next == flash_guard_pkg::SECURE_CODE);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg <= 1'b0;
      keysel_reg <= 1'b0;
      backdoor_unlock_enable_reg <= 1'b0;
      code_reg <= '0;
      secure_reg <= 1'b0;
      guard_reg <= '0;
      priv_reg <= '0;
      fetch_reg <= '0;
    end else begin
      lock_reg <= lock_next;
      keysel_reg <= keysel_next;
      backdoor_unlock_enable_reg <= backdoor_unlock_enable_next;
      code_reg <= code_next;
      secure_reg <= secure_next;
      guard_reg <= guard_next;
      priv_reg <= priv_next;
      fetch_reg <= fetch_next;
    end
  end

  // ==========================================================================
  // Command status flags
  // ==========================================================================
  always_comb begin
    status_next = status_reg;
    // Write one clears; a set pulse in the same cycle wins so no event is lost.
    if (wr_status) begin
      status_next[flash_guard_pkg::CMD_BUFFER_EMPTY_FLAG_BIT] = status_reg[flash_guard_pkg::CMD_BUFFER_EMPTY_FLAG_BIT]
        & ~reg_wdata[flash_guard_pkg::CMD_BUFFER_EMPTY_FLAG_BIT];
      status_next[flash_guard_pkg::PROTECTION_VIOLATION_FLAG_BIT] = status_reg[flash_guard_pkg::PROTECTION_VIOLATION_FLAG_BIT]
        & ~reg_wdata[flash_guard_pkg::PROTECTION_VIOLATION_FLAG_BIT];
      status_next[flash_guard_pkg::ACCESS_ERROR_FLAG_BIT] = status_reg[flash_guard_pkg::ACCESS_ERROR_FLAG_BIT]
        & ~reg_wdata[flash_guard_pkg::ACCESS_ERROR_FLAG_BIT];
      status_next[flash_guard_pkg::BLANK_BIT] = status_reg[flash_guard_pkg::BLANK_BIT]
        & ~reg_wdata[flash_guard_pkg::BLANK_BIT];
    end
    if (flag_set.cmd_buffer_empty_flag) begin
      status_next[flash_guard_pkg::CMD_BUFFER_EMPTY_FLAG_BIT] = 1'b1;
    end
    if (prot_event) begin
      status_next[flash_guard_pkg::PROTECTION_VIOLATION_FLAG_BIT] = 1'b1;
    end
    if (flag_set.access_error_flag) begin
      status_next[flash_guard_pkg::ACCESS_ERROR_FLAG_BIT] = 1'b1;
    end
    if (flag_set.blank) begin
      status_next[flash_guard_pkg::BLANK_BIT] = 1'b1;
    end
    status_next[flash_guard_pkg::CMD_COMPLETE_FLAG_BIT] = cmd_complete;
    status_next[3] = 1'b0;
    status_next[1:0] = 2'h0;
    block_next = status_next[flash_guard_pkg::PROTECTION_VIOLATION_FLAG_BIT] | status_next[flash_guard_pkg::ACCESS_ERROR_FLAG_BIT];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= flash_guard_pkg::STATUS_RESET;
      block_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      block_reg <= block_next;
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        flash_guard_pkg::CTRL_OFS: begin
          rdata_next[flash_guard_pkg::LOCK_BIT] = lock_reg;
          rdata_next[flash_guard_pkg::KEYSEL_BIT] = keysel_reg;
        end
        flash_guard_pkg::LOCKOUT_OFS: begin
          rdata_next[flash_guard_pkg::BACKDOOR_UNLOCK_ENABLE_BIT] = backdoor_unlock_enable_reg;
          rdata_next[flash_guard_pkg::LOCKOUT_STATE_BIT_BIT] = secure_reg;
          rdata_next[flash_guard_pkg::CODE_W-1:0] = code_reg;
        end
        flash_guard_pkg::GUARD_OFS: rdata_next = guard_reg;
        flash_guard_pkg::PRIV_OFS: rdata_next = priv_reg;
        flash_guard_pkg::FETCH_OFS: rdata_next = fetch_reg;
        flash_guard_pkg::STATUS_OFS: rdata_next[flash_guard_pkg::STATUS_W-1:0] = status_reg;
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign status_out_bus = status_reg;
  assign cmd_launch_block = block_reg;
  assign key_write_select = keysel_reg;
  assign backdoor_unlock_enable = backdoor_unlock_enable_reg;
  assign lockout_state_bit = secure_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_lockout_readonly: assert property (wr_ctrl ##0 !ld_strobe |=> $stable(code_reg) && $stable(backdoor_unlock_enable_reg))
    else $error("lockout word changed by a register write");
  a_lockout_rsvd: assert property (reg_rd && reg_addr == flash_guard_pkg::LOCKOUT_OFS |=>
    reg_rdata[29:16] == 14'h0000 && reg_rdata[15:0] == code_reg)
    else $error("lockout read shows reserved bits or wrong code");
  a_secure_code: assert property (ld_strobe && ld_sel == flash_guard_pkg::LD_LOCKOUT |=>
    lockout_state_bit == ($past(ld_data[15:0]) == flash_guard_pkg::SECURE_CODE))
    else $error("security state does not follow the loaded code word");
  a_guard_locked: assert property (lock_reg && !ld_strobe |=> $stable(guard_reg))
    else $error("guard mask changed while locked");
  a_priv_locked: assert property (lock_reg && wr_priv && !ld_strobe |=> priv_reg == $past(priv_reg))
    else $error("privilege mask written while locked");
  a_fetch_locked: assert property (lock_reg && wr_fetch && !ld_strobe |=> $stable(fetch_reg))
    else $error("fetch mask written while locked");
  a_lock_sticky: assert property (lock_reg |=> lock_reg)
    else $error("lock bit cleared after it was set");
  a_keysel_gate: assert property (!backdoor_unlock_enable_reg |=> !key_write_select)
    else $error("key select set without backdoor enable");
  a_viol_blocks: assert property (prot_event |=> ##1 cmd_launch_block)
    else $error("violation did not block command launch");
  a_status_read: assert property (reg_rd && reg_addr == flash_guard_pkg::STATUS_OFS |=>
    reg_rdata[7:0] == $past(status_out_bus) && reg_rdata[3] == 1'b0)
    else $error("status bus differs from status register");
  a_cmd_complete_flag_ro: assert property (wr_status |=> status_reg[flash_guard_pkg::CMD_COMPLETE_FLAG_BIT] == $past(cmd_complete))
    else $error("complete flag altered by a write");

  c_load_done: cover property ($rose(load_done));
  c_lock_then_write: cover property (lock_reg && wr_guard);
  c_violation: cover property (prot_event ##2 wr_status);
  c_secured: cover property ($rose(lockout_state_bit));

endmodule : flash_sector_access_guard

// ===== sim/cfg_flash_model.sv
// Behavioural flash array that serves the configuration words read at reset.
`timescale 1ns/1ns
module cfg_flash_model #(
  parameter int LAT = 3,
  parameter logic [31:0] GUARD = 32'h0000_0002,
  parameter logic [31:0] PRIV = 32'h0000_0004,
  parameter logic [31:0] FETCH = 32'h0000_0008,
  parameter logic [31:0] LOCKOUT = 32'h8FFF_4AC8
) (
  input wire logic sys_clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic cfg_req, // Word request.
  input wire logic [15:0] cfg_addr, // Word offset.
  output logic cfg_valid, // Word present.
  output logic [31:0] cfg_data // Word read.
);
  logic [3:0] wait_reg;
  logic [31:0] word;
  // ==========================================================================
  // Configuration field contents
  // ==========================================================================
  always_comb begin
    case (cfg_addr)
      16'h0410: word = GUARD;
      16'h0408: word = PRIV;
      16'h040C: word = FETCH;
      16'h0414: word = LOCKOUT;
      default: word = 32'h0;
    endcase
  end
  // A slow array: the answer comes only after LAT waiting cycles.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) wait_reg <= 4'h0;
    else wait_reg <= (cfg_req && !cfg_valid) ? wait_reg + 4'h1 : 4'h0;
  end
  assign cfg_valid = cfg_req && (wait_reg == 4'(LAT));
  // Outside a valid cycle the lines show garbage, never the stale word.
  assign cfg_data = cfg_valid ? word : ~word;
endmodule : cfg_flash_model

// ===== sim/flash_sector_access_guard_tb.sv
// Self-checking testbench of the flash sector access guard.
`timescale 1ns/1ns
module flash_sector_access_guard_tb;
  logic sys_clk, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, cmd_complete = 1'h1;
  logic cfg_req, cfg_valid, load_done, acc_done, acc_bus_err, acc_grant;
  logic cmd_launch_block, key_write_select, backdoor_unlock_enable, lockout_state_bit;
  logic [7:0] reg_addr = 8'h00, status_out_bus;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, cfg_data;
  logic [15:0] cfg_addr;
  flash_guard_pkg::acc_req_s acc_req = '0;
  flash_guard_pkg::flag_set_s flag_set = '0;
  int n_mismatch, checks_done;
  localparam logic [31:0] G = 32'h0000_0002;
  flash_sector_access_guard dut (.*);
  cfg_flash_model #(.LAT(3), .GUARD(G), .PRIV(G << 1), .FETCH(G << 2)) far (.*);
  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 chk(reg_rdata, e);
  endtask : rd
  task automatic acc(input logic w, u, f, input logic [4:0] s, input logic [1:0] eg);
    @(posedge sys_clk);
    acc_req <= '{1'h1, w, u, f, {s, 13'h0000}};
    @(posedge sys_clk);
    acc_req <= '0;
    #1 chk({acc_done, acc_bus_err, acc_grant}, {1'h1, eg});
  endtask : acc
  task automatic close_out();
    if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // ==========================================================================
  // Clock, watchdog and test sequence
  // ==========================================================================
  initial begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  // The sequence needs about 130 cycles; this allows 25000 cycles, some two hundred times that.
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 200 && load_done !== 1'h1; i++) @(posedge sys_clk);
    rd(8'h04, 32'hC000_4AC8);
    chk({backdoor_unlock_enable, lockout_state_bit}, 2'h3);
    wr(8'h04, 32'h0);
    rd(8'h04, 32'hC000_4AC8);
    for (int i = 0; i < 3; i++) rd(8'h08 + 8'(4 * i), G << i);
    rd(8'h18, 32'h0);
    acc(1'h1, 1'h0, 1'h0, 5'h01, 2'h0);
    repeat (2) @(posedge sys_clk);
    #1 chk({status_out_bus[5], cmd_launch_block}, 2'h3);
    acc(1'h1, 1'h0, 1'h0, 5'h00, 2'h0);
    wr(8'h14, 32'h20);
    repeat (2) @(posedge sys_clk);
    acc(1'h1, 1'h0, 1'h0, 5'h00, 2'h1);
    acc(1'h0, 1'h1, 1'h0, 5'h02, 2'h2);
    acc(1'h0, 1'h0, 1'h0, 5'h02, 2'h0);
    acc(1'h0, 1'h0, 1'h1, 5'h03, 2'h2);
    acc(1'h0, 1'h1, 1'h1, 5'h04, 2'h0);
    @(posedge sys_clk);
    flag_set <= '{1'h1, 1'h1, 1'h1};
    @(posedge sys_clk);
    flag_set <= '0;
    rd(8'h14, 32'hD4);
    chk(status_out_bus, 8'hD4);
    wr(8'h14, 32'h40);
    wr(8'h14, 32'h10);
    cmd_complete <= 1'h0;
    rd(8'h14, 32'h84);
    wr(8'h14, 32'h80);
    rd(8'h14, 32'h04);
    chk(status_out_bus, 8'h04);
    // A set pulse in the same cycle as the clear of that flag must win.
    fork
      wr(8'h14, 32'h04);
      begin
        @(posedge sys_clk);
        flag_set <= 3'h1;
        @(posedge sys_clk);
        flag_set <= '0;
      end
    join
    rd(8'h14, 32'h04);
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 3; i++) begin
        wr(8'h08 + 8'(4 * i), j ? 32'h0 : 32'h5A00_0000 | (G << i));
        rd(8'h08 + 8'(4 * i), 32'h5A00_0000 | (G << i));
      end
      wr(8'h00, 32'h420);
    end
    chk(key_write_select, 1'h1);
    rd(8'h00, 32'h420);
    wr(8'h00, 32'h0);
    rd(8'h00, 32'h400);
    close_out();
  end
endmodule : flash_sector_access_guard_tb
